/* File: design/hpsc_regs.svh */
// Timing and I/O charge-current constants for the hot-plug slot power and fault control block.
`ifndef HPSC_REGS_SVH
`define HPSC_REGS_SVH
`define HPSC_CLK_MHZ        100
`define HPSC_OVL_TIMEOUT_MS 5
`define HPSC_OVL_TIMEOUT_CYC (`HPSC_OVL_TIMEOUT_MS * 1000 * `HPSC_CLK_MHZ)
`define HPSC_OVL_CLEAR_US   100
`define HPSC_OVL_CLEAR_CYC  (`HPSC_OVL_CLEAR_US * `HPSC_CLK_MHZ)
`define HPSC_FAST_OFF_US    3
`define HPSC_FAST_OFF_CYC   (`HPSC_FAST_OFF_US * `HPSC_CLK_MHZ)
`define HPSC_AUX_RAMP_CYC   1000
`define HPSC_EVT_DELAY_CYC  1000
`define HPSC_IO_CHARGE_UA   10
`endif

/* File: design/hpsc_pkg.sv */
// Types for the hot-plug slot power and fault control block.
package hpsc_pkg;
  typedef enum logic [1:0] {
    AUX_OFF  = 2'b00,
    AUX_RAMP = 2'b01,
    AUX_WAIT = 2'b10,
    AUX_ON   = 2'b11
  } hpsc_aux_t;

  typedef struct packed {
    logic main_ovl;
    logic p12_oc;
    logic aux_oc;
  } hpsc_flt_t;

  typedef struct packed {
    logic main_gate;
    logic low_io_voltage_gate;
    logic high_io_voltage_gate;
    logic regulating;
    logic main_fault;
    logic p12_gate;
    logic n12_gate;
    logic slot_aux_power;
    logic aux_fault;
    logic event_oe;
    logic event_out;
    logic io_charge_to_low;
  } hpsc_out_t;
endpackage : hpsc_pkg

/* File: design/hpsc_sync.sv */
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/100ps
module hpsc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hpsc_sync_st_t;
  hpsc_sync_st_t st_r;
  hpsc_sync_st_t st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule : hpsc_sync

/* File: design/hpsc_slot.sv */
// Per-slot main, secondary, I/O-voltage and auxiliary power control with event gating.
// Overview of operation
// (RULE1) Main overload enters regulation, starts 5 ms timer.
// (RULE2) Timeout under overload latches main fault off.
// (RULE3) Overload absent over 100 us clears regulation.
// (RULE4) 12V, -12V, aux overcurrent: off after 3 us. No -12V sense input here; p12_oc trips both 12 V gates.
// (RULE5) Negative 12 V follows positive 12 V gate.
// (RULE6) Enable ramps one selected I/O gate up.
// (RULE7) Disable ramps I/O gate down with mains.
// (RULE8) One I/O charge source steered by select.
// (RULE9) Host picks I/O voltage by bus mode.
// (RULE10) Switch closed starts auxiliary power ramp at once.
// (RULE11) Delay after aux ramp, then connect event.
// (RULE12) Aux fault drops aux power and event.
// (RULE13) Aux fault holds until switch opens.
// (RULE14) Switch open or fault opens event gate.
// (RULE15) Event output never drives inactive high level.
// (RULE16) Host may derive select from capability bit.
// (RULE17) Reset clears latches, timers, gates, event paths.
// (RULE18) Aux fault also forces main power off.
`timescale 1ns/100ps
`include "hpsc_regs.svh"
module hpsc_slot #(
  parameter int OVL_TIMEOUT_CYC = `HPSC_OVL_TIMEOUT_CYC,
  parameter int OVL_CLEAR_CYC   = `HPSC_OVL_CLEAR_CYC,
  parameter int FAST_OFF_CYC    = `HPSC_FAST_OFF_CYC,
  parameter int AUX_RAMP_CYC    = `HPSC_AUX_RAMP_CYC,
  parameter int EVT_DELAY_CYC   = `HPSC_EVT_DELAY_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire logic          slot_power_enable,
  input  wire logic          io_voltage_select,
  input  wire logic          slot_aux_switch_in_n,
  input  wire logic          slot_event_in_n,
  input  hpsc_pkg::hpsc_flt_t flt_in,
  output hpsc_pkg::hpsc_out_t outs
);
  localparam int CW = 32;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [6:0] pin_s;
  // Pins are flipped so that a cleared synchroniser reads as idle: switch open, no event
  // and 3.3 V select. Otherwise every reset would look like a switch closure.
  hpsc_sync #(.W(7)) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d       ({slot_power_enable, !io_voltage_select, !slot_aux_switch_in_n,
                !slot_event_in_n, flt_in.main_ovl, flt_in.p12_oc, flt_in.aux_oc}),
    .q       (pin_s)
  );
  logic en_s, lo_sel_s, sw_closed_s, evt_act_s, ovl_s, p12_s, aux_s;
  logic sw_n_s, evt_n_s;
  assign {en_s, lo_sel_s, sw_closed_s, evt_act_s, ovl_s, p12_s, aux_s} = pin_s;
  assign sw_n_s  = !sw_closed_s;
  assign evt_n_s = !evt_act_s;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hpsc_pkg::hpsc_out_t o;
    hpsc_pkg::hpsc_aux_t aux_st;
    logic [CW-1:0]       ovl_cnt;
    logic [CW-1:0]       clr_cnt;
    logic [CW-1:0]       p12_cnt;
    logic [CW-1:0]       auxo_cnt;
    logic [CW-1:0]       aux_cnt;
    logic                p12_fault;
  } hpsc_slot_st_t;

  hpsc_slot_st_t st_r;
  hpsc_slot_st_t st_nxt;

  always_comb begin
    logic main_on;
    main_on = 1'b0;
    st_nxt  = st_r;
    // Dropping enable is the only way out of a main fault apart from reset.
    if (!en_s) begin
      st_nxt.o.main_fault = 1'b0; // RULE2
      st_nxt.p12_fault    = 1'b0;
    end
    // Main overload regulation and timeout.
    if (st_r.o.main_gate && ovl_s) begin
      st_nxt.o.regulating = 1'b1; // RULE1
      st_nxt.clr_cnt      = '0;
    end else if (st_r.o.regulating) begin
      st_nxt.clr_cnt = st_r.clr_cnt + 1'b1;
      if (st_r.clr_cnt >= CW'(OVL_CLEAR_CYC)) begin
        st_nxt.o.regulating = 1'b0; // RULE3
        st_nxt.ovl_cnt      = '0;
      end
    end
    // The timer only runs while regulation stays set, so a clear above leaves it at zero.
    if (st_r.o.regulating && st_nxt.o.regulating) begin
      st_nxt.ovl_cnt = st_r.ovl_cnt + 1'b1;
      if (st_r.ovl_cnt >= CW'(OVL_TIMEOUT_CYC - 1) && ovl_s) begin
        st_nxt.o.main_fault = 1'b1; // RULE2
        st_nxt.o.regulating = 1'b0;
        st_nxt.ovl_cnt      = '0;
      end
    end
    // Secondary supply overcurrent: fixed delay, no regulation phase.
    if (st_r.o.p12_gate && p12_s) begin
      st_nxt.p12_cnt = st_r.p12_cnt + 1'b1;
      if (st_r.p12_cnt >= CW'(FAST_OFF_CYC - 1)) begin
        st_nxt.p12_fault = 1'b1; // RULE4
      end
    end else begin
      st_nxt.p12_cnt = '0;
    end
    // Opening the switch clears the latch, but a fault in the same cycle still sets it.
    if (sw_n_s) begin
      st_nxt.o.aux_fault = 1'b0; // RULE13
    end
    // Auxiliary overcurrent: same fixed delay, then latched.
    if (st_r.o.slot_aux_power && aux_s) begin
      st_nxt.auxo_cnt = st_r.auxo_cnt + 1'b1;
      if (st_r.auxo_cnt >= CW'(FAST_OFF_CYC - 1)) begin
        st_nxt.o.aux_fault = 1'b1; // RULE4
      end
    end else begin
      st_nxt.auxo_cnt = '0;
    end
    // Auxiliary power sequencing.
    case (st_r.aux_st)
      hpsc_pkg::AUX_OFF: begin
        if (!sw_n_s && !st_r.o.aux_fault) begin
          st_nxt.aux_st  = hpsc_pkg::AUX_RAMP; // RULE10
          st_nxt.aux_cnt = '0;
        end
      end
      hpsc_pkg::AUX_RAMP: begin
        st_nxt.aux_cnt = st_r.aux_cnt + 1'b1;
        if (st_r.aux_cnt >= CW'(AUX_RAMP_CYC - 1)) begin
          st_nxt.aux_st  = hpsc_pkg::AUX_WAIT; // RULE11
          st_nxt.aux_cnt = '0;
        end
      end
      hpsc_pkg::AUX_WAIT: begin
        st_nxt.aux_cnt = st_r.aux_cnt + 1'b1;
        if (st_r.aux_cnt >= CW'(EVT_DELAY_CYC - 1)) begin
          st_nxt.aux_st = hpsc_pkg::AUX_ON; // RULE11
        end
      end
      default: begin
      end
    endcase
    if (sw_n_s || st_nxt.o.aux_fault) begin
      st_nxt.aux_st  = hpsc_pkg::AUX_OFF; // RULE12 RULE14
      st_nxt.aux_cnt = '0;
    end
    // Main gating follows enable unless a main or aux fault holds the slot off.
    main_on = en_s && !st_nxt.o.main_fault && !st_nxt.o.aux_fault; // RULE18
    st_nxt.o.main_gate            = main_on; // RULE7
    // Select low picks the 1.5 V gate, so an inverted capability bit can drive it.
    st_nxt.o.high_io_voltage_gate = main_on && !lo_sel_s; // RULE6
    st_nxt.o.low_io_voltage_gate  = main_on && lo_sel_s; // RULE6
    st_nxt.o.io_charge_to_low     = lo_sel_s; // RULE8
    st_nxt.o.p12_gate             = main_on && !st_nxt.p12_fault;
    st_nxt.o.n12_gate             = main_on && !st_nxt.p12_fault; // RULE5
    st_nxt.o.slot_aux_power       = st_nxt.aux_st != hpsc_pkg::AUX_OFF;
    // Open-drain event: only ever pulls low, so slots can share a node.
    st_nxt.o.event_out = 1'b0; // RULE15
    st_nxt.o.event_oe  = (st_nxt.aux_st == hpsc_pkg::AUX_ON) && !evt_n_s; // RULE14
    if (!main_on) begin
      st_nxt.o.regulating = 1'b0;
      st_nxt.ovl_cnt      = '0;
      st_nxt.clr_cnt      = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0; // RULE17
    end else begin
      st_r <= st_nxt;
    end
  end

  assign outs = st_r.o;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fault_kills_main: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.o.main_fault |-> !st_r.o.main_gate) else $error("main gate on in fault"); // RULE2
  a_aux_fault_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.o.aux_fault |-> !st_r.o.slot_aux_power && !st_r.o.event_oe && !st_r.o.main_gate)
    else $error("aux fault left power on"); // RULE12
  a_one_io_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(st_r.o.low_io_voltage_gate && st_r.o.high_io_voltage_gate))
    else $error("both io gates on"); // RULE6
  a_io_follows_main: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.o.main_gate == (st_r.o.low_io_voltage_gate || st_r.o.high_io_voltage_gate))
    else $error("io gate not with main"); // RULE7
  a_neg_follows_pos: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.o.n12_gate == st_r.o.p12_gate) else $error("neg rail diverged"); // RULE5
  a_never_drive_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.o.event_oe |-> !st_r.o.event_out) else $error("event drove high"); // RULE15
  a_switch_open_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sw_n_s |=> !st_r.o.slot_aux_power && !st_r.o.event_oe)
    else $error("switch open left aux on"); // RULE14
  a_switch_close_ramp: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(sw_n_s) && !st_r.o.aux_fault && !aux_s |=> st_r.o.slot_aux_power)
    else $error("aux ramp did not start"); // RULE10
  a_regulate_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.o.main_gate && ovl_s && en_s && !st_r.o.main_fault && !st_r.o.aux_fault
    |=> st_r.o.regulating || st_r.o.main_fault) else $error("no regulation"); // RULE1
  a_charge_steer: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.o.low_io_voltage_gate |-> st_r.o.io_charge_to_low)
    else $error("charge source misrouted"); // RULE8
  c_main_fault: cover property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(st_r.o.main_fault));
  c_reg_clear: cover property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(st_r.o.regulating) && !st_r.o.main_fault);
  c_event_on: cover property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(st_r.aux_st == hpsc_pkg::AUX_ON));
  c_aux_fault: cover property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(st_r.o.aux_fault));
endmodule : hpsc_slot

/* File: dv/hpsc_host_model.sv */
// Behavioural model of the host slot controller that drives enable and select.
`timescale 1ns/100ps
module hpsc_host_model (
  input  wire logic sys_clk,
  input  wire logic power_req,
  input  wire logic capability_bit_three,
  output logic      slot_power_enable,
  output logic      io_voltage_select
);
  // ------------------------------------------------------------
  // Host drive
  // ------------------------------------------------------------
  // Select low picks the 1.5 V gate, so the capability bit passes through an inverter.
  initial begin
    slot_power_enable = 1'b0;
    io_voltage_select = 1'b0;
    forever begin
      @(negedge sys_clk);
      slot_power_enable <= power_req;
      io_voltage_select <= !capability_bit_three;
    end
  end
endmodule : hpsc_host_model

/* File: dv/hpsc_slot_tb_top.sv */
// Self-checking bench for one slot of the hot-plug power and fault control block.
`timescale 1ns/100ps
module hpsc_slot_tb_top;
  logic                sys_clk;
  logic                arst_n;
  logic                power_req;
  logic                cap_bit;
  logic                slot_power_enable;
  logic                io_voltage_select;
  logic                aux_sw_n;
  logic                evt_n;
  hpsc_pkg::hpsc_flt_t flt;
  hpsc_pkg::hpsc_out_t outs;
  int                  errors;
  int                  n_checks;

  hpsc_host_model host (.sys_clk(sys_clk), .power_req(power_req),
    .capability_bit_three(cap_bit), .slot_power_enable(slot_power_enable),
    .io_voltage_select(io_voltage_select));

  // Short counts keep the run brief; expectations scale with them.
  hpsc_slot #(.OVL_TIMEOUT_CYC(50), .OVL_CLEAR_CYC(10), .FAST_OFF_CYC(5),
    .AUX_RAMP_CYC(8), .EVT_DELAY_CYC(8)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .slot_power_enable(slot_power_enable), .io_voltage_select(io_voltage_select),
    .slot_aux_switch_in_n(aux_sw_n), .slot_event_in_n(evt_n), .flt_in(flt), .outs(outs));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic seen, input logic exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check

  task automatic run(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : run

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    stop_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    power_req = 1'b0;
    cap_bit = 1'b0;
    aux_sw_n = 1'b1;
    evt_n = 1'b1;
    flt = '0;
    errors = 0;
    n_checks = 0;
    run(10);
    check(outs === 12'h000, 1'b1, "outs in reset");
    arst_n = 1'b1;
    run(1);
    check(outs === 12'h000, 1'b1, "outs after reset");
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      cap_bit = s[0];
      power_req = 1'b1;
      run(6);
      check(outs.main_gate, 1'b1, "main gate on");
      check(outs.low_io_voltage_gate, s[0], "low io gate");
      check(outs.high_io_voltage_gate, ~s[0], "high io gate");
      check(outs.io_charge_to_low, s[0], "charge steering");
      check(outs.p12_gate & outs.n12_gate, 1'b1, "12 V gates on");
      power_req = 1'b0;
      run(6);
      check(outs.main_gate | outs.low_io_voltage_gate | outs.high_io_voltage_gate,
        1'b0, "gates off");
      check(outs.n12_gate, 1'b0, "neg 12 V off");
    end
    $display("test power done");
    power_req = 1'b1;
    run(6);
    flt.main_ovl = 1'b1;
    run(5);
    check(outs.regulating, 1'b1, "regulation entered");
    check(outs.main_fault, 1'b0, "early fault");
    flt.main_ovl = 1'b0;
    run(16);
    check(outs.regulating | outs.main_fault, 1'b0, "regulation cleared");
    flt.main_ovl = 1'b1;
    run(40);
    check(outs.main_fault, 1'b0, "fault before timeout");
    run(20);
    check(outs.main_fault, 1'b1, "fault after timeout");
    check(outs.main_gate, 1'b0, "main off on fault");
    flt.main_ovl = 1'b0;
    run(6);
    check(outs.main_gate, 1'b0, "fault holds");
    power_req = 1'b0;
    run(6);
    power_req = 1'b1;
    run(6);
    check(outs.main_fault, 1'b0, "fault cleared by cycle");
    check(outs.main_gate, 1'b1, "main back on");
    $display("test overload done");
    flt.p12_oc = 1'b1;
    run(3);
    check(outs.p12_gate, 1'b1, "no early trip");
    run(12);
    check(outs.p12_gate | outs.n12_gate, 1'b0, "12 V tripped");
    check(outs.regulating, 1'b0, "no regulation");
    flt.p12_oc = 1'b0;
    power_req = 1'b0;
    run(6);
    $display("test fast trip done");
    evt_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      aux_sw_n = 1'b0;
      run(5);
      check(outs.slot_aux_power, 1'b1, "aux on");
      check(outs.event_oe, 1'b0, "event early");
      run(30);
      check(outs.event_oe, 1'b1, "event connected");
      check(outs.event_out, 1'b0, "event level");
      evt_n = 1'b1;
      run(4);
      check(outs.event_oe, 1'b0, "idle event not driven");
      evt_n = 1'b0;
      run(4);
      check(outs.event_oe, 1'b1, "event reconnected");
      if (k == 0) begin
        aux_sw_n = 1'b1;
        run(4);
        check(outs.event_oe | outs.slot_aux_power, 1'b0, "switch open");
      end
    end
    power_req = 1'b1;
    run(6);
    flt.aux_oc = 1'b1;
    run(12);
    check(outs.slot_aux_power | outs.event_oe, 1'b0, "aux fault drop");
    check(outs.main_gate, 1'b0, "main off on aux fault");
    flt.aux_oc = 1'b0;
    run(20);
    check(outs.aux_fault, 1'b1, "aux fault held");
    check(outs.slot_aux_power, 1'b0, "aux stays off");
    aux_sw_n = 1'b1;
    run(6);
    check(outs.aux_fault, 1'b0, "aux fault cleared");
    $display("test aux done");
    stop_test();
  end
endmodule : hpsc_slot_tb_top
